// ---- shared/srb_pkg.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants and helpers for the sensor register bank.
// Assumes: One system clock; serial pins are sampled on that clock.
// Notes:   Offsets are the byte addresses of the 8-bit registers.
//////////////////////////////////////////////////////////////////////////////
package srb_pkg;

  // Register width and register address width.
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 7;
  // Width of the assembled reference and output pressure.
  localparam int unsigned PRESS_W = 24;
  // Width of the temperature sample.
  localparam int unsigned TEMP_W = 16;

  //////////////////////////////////////////////////////////////////////////
  // Register offsets.
  localparam logic [6:0] OFS_REF_LOW = 7'h08;
  localparam logic [6:0] OFS_REF_MID = 7'h09;
  localparam logic [6:0] OFS_REF_HIGH = 7'h0A;
  localparam logic [6:0] OFS_IDENTITY = 7'h0F;
  localparam logic [6:0] OFS_AVG_CONFIG = 7'h10;
  localparam logic [6:0] OFS_CONTROL_ONE = 7'h20;
  localparam logic [6:0] OFS_CONTROL_TWO = 7'h21;
  localparam logic [6:0] OFS_CONTROL_THREE = 7'h22;
  localparam logic [6:0] OFS_CONTROL_FOUR = 7'h23;
  localparam logic [6:0] OFS_EVENT_CONFIG = 7'h24;
  localparam logic [6:0] OFS_EVENT_SOURCE = 7'h25;
  localparam logic [6:0] OFS_SAMPLE_STATUS = 7'h27;
  localparam logic [6:0] OFS_PRESS_LOW = 7'h28;
  localparam logic [6:0] OFS_PRESS_MID = 7'h29;
  localparam logic [6:0] OFS_PRESS_HIGH = 7'h2A;
  localparam logic [6:0] OFS_TEMP_LOW = 7'h2B;
  localparam logic [6:0] OFS_TEMP_HIGH = 7'h2C;
  localparam logic [6:0] OFS_QUEUE_CONTROL = 7'h2E;
  localparam logic [6:0] OFS_QUEUE_STATUS = 7'h2F;
  localparam logic [6:0] OFS_THRESH_LOW = 7'h30;
  localparam logic [6:0] OFS_THRESH_HIGH = 7'h31;
  localparam logic [6:0] OFS_OFFSET_LOW = 7'h39;
  localparam logic [6:0] OFS_OFFSET_HIGH = 7'h3A;

  //////////////////////////////////////////////////////////////////////////
  // Values after reset; the calibration defaults are restored on power-up.
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_AVG_CONFIG = 8'h05;
  localparam logic [7:0] RST_OFFSET_LOW = 8'h38;
  localparam logic [7:0] RST_OFFSET_HIGH = 8'h00;

  //////////////////////////////////////////////////////////////////////////
  // Serial command field positions, first bit on the wire is bit 7.
  localparam int unsigned CMD_RNW_BIT = 7;
  localparam int unsigned CMD_INC_BIT = 6;
  localparam int unsigned CMD_ADDR_MSB = 5;
  // Top bit of the two-wire sub-address selects auto increment.
  localparam int unsigned SUB_INC_BIT = 7;
  // Bit count value of the last bit of a serial byte.
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Address for the next byte of a multi-byte access.
  function automatic logic [ADDR_W-1:0] srb_next_addr(
    input logic [ADDR_W-1:0] addr,
    input logic inc
  );
    srb_next_addr = inc ? ADDR_W'(addr + 7'h01) : addr;
  endfunction

endpackage

// ---- design/srb_pressure_adder.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: Adds the signed reference pressure to the raw pressure sample.
// Assumes: Both operands are two's complement of the same width.
// Notes:   The sum wraps; the sensor range keeps it far from overflow.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
module srb_pressure_adder
#(
  parameter int unsigned WIDTH = srb_pkg::PRESS_W
)
(
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Operands.
  input wire logic [WIDTH-1:0] i_raw_pressure,
  input wire logic [WIDTH-1:0] i_ref_pressure,
  // Registered sum.
  output logic [WIDTH-1:0] o_pressure
);
  import srb_pkg::*;

  // Sum register and its next value.
  logic [WIDTH-1:0] sum_q;
  logic [WIDTH-1:0] sum_d;

  // The reference is treated as signed, so a plain wrap add is exact.
  always_comb
  begin
    sum_d = WIDTH'($signed(i_raw_pressure) + $signed(i_ref_pressure));
  end

  // Register the sum so the readable output bytes come from flip-flops.
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sum_q <= '0;
    end
    else
    begin
      sum_q <= sum_d;
    end
  end

  assign o_pressure = sum_q;

endmodule

// ---- design/srb_spi_slave.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: Four-wire serial slave that turns frames into register access.
// Assumes: Each serial clock phase lasts at least two system clocks.
// Notes:   Serial clock idles high; data is taken on its rising edge.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
module srb_spi_slave
(
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Serial pins.
  input wire logic i_spi_cs_b,
  input wire logic i_spi_clk,
  input wire logic i_spi_sdi,
  output logic o_spi_sdo,
  output logic o_spi_sdo_oe,
  // Register side.
  output logic [srb_pkg::ADDR_W-1:0] o_rd_addr,
  input wire logic [srb_pkg::DATA_W-1:0] i_rd_data,
  output logic o_wr_vld,
  output logic [srb_pkg::ADDR_W-1:0] o_wr_addr,
  output logic [srb_pkg::DATA_W-1:0] o_wr_data
);
  import srb_pkg::*;

  // Previous serial clock level, for edge detection.
  logic clk_q, clk_d;
  // Bit position inside the current byte.
  logic [2:0] bit_cnt_q, bit_cnt_d;
  // Receive and transmit shifters.
  logic [7:0] in_sr_q, in_sr_d;
  logic [7:0] out_sr_q, out_sr_d;
  // Command decoded for this frame.
  logic cmd_done_q, cmd_done_d;
  logic rnw_q, rnw_d;
  logic inc_q, inc_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  // Pending load of the read shifter, one cycle after the address settles.
  logic load_q, load_d;
  // Output pin and write strobe registers.
  logic sdo_q, sdo_d;
  logic oe_q, oe_d;
  logic wr_vld_q, wr_vld_d;
  logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;
  logic [7:0] wr_data_q, wr_data_d;
  // Edge flags and the byte just completed.
  logic rise;
  logic fall;
  logic [7:0] byte_in;

  //////////////////////////////////////////////////////////////////////////
  // Frame decoding: command byte, then data bytes of eight bits each.
  always_comb
  begin
    rise = !i_spi_cs_b && i_spi_clk && !clk_q;
    fall = !i_spi_cs_b && !i_spi_clk && clk_q;
    byte_in = {in_sr_q[6:0], i_spi_sdi};
    clk_d = i_spi_clk;
    bit_cnt_d = bit_cnt_q;
    in_sr_d = in_sr_q;
    out_sr_d = out_sr_q;
    cmd_done_d = cmd_done_q;
    rnw_d = rnw_q;
    inc_d = inc_q;
    addr_d = addr_q;
    load_d = 1'b0;
    sdo_d = sdo_q;
    oe_d = oe_q;
    wr_vld_d = 1'b0;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    if (i_spi_cs_b)
    begin
      // A deselect ends the frame and releases the output pin.
      bit_cnt_d = 3'h0;
      cmd_done_d = 1'b0;
      oe_d = 1'b0;
    end
    else
    begin
      if (rise)
      begin
        in_sr_d = byte_in;
        bit_cnt_d = 3'(bit_cnt_q + 3'h1);
        if (bit_cnt_q == LAST_BIT)
        begin
          if (!cmd_done_q)
          begin
            // Command byte: direction, increment flag, register address.
            cmd_done_d = 1'b1;
            rnw_d = byte_in[CMD_RNW_BIT];
            inc_d = byte_in[CMD_INC_BIT];
            addr_d = {1'b0, byte_in[CMD_ADDR_MSB:0]};
            load_d = byte_in[CMD_RNW_BIT];
          end
          else if (rnw_q)
          begin
            // Next read byte comes from the same or the next address.
            addr_d = srb_next_addr(addr_q, inc_q);
            load_d = 1'b1;
          end
          else
          begin
            // A full data byte is written, then the address moves on.
            wr_vld_d = 1'b1;
            wr_addr_d = addr_q;
            wr_data_d = byte_in;
            addr_d = srb_next_addr(addr_q, inc_q);
          end
        end
      end
      if (fall && cmd_done_q && rnw_q)
      begin
        // Drive from the start of the first data bit, MSb first.
        oe_d = 1'b1;
        sdo_d = out_sr_q[7];
        out_sr_d = {out_sr_q[6:0], 1'b0};
      end
      if (load_q)
      begin
        out_sr_d = i_rd_data;
      end
    end
  end

  // State registers only.
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      clk_q <= 1'b1;
      bit_cnt_q <= 3'h0;
      in_sr_q <= 8'h00;
      out_sr_q <= 8'h00;
      cmd_done_q <= 1'b0;
      rnw_q <= 1'b0;
      inc_q <= 1'b0;
      addr_q <= 7'h00;
      load_q <= 1'b0;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
      wr_vld_q <= 1'b0;
      wr_addr_q <= 7'h00;
      wr_data_q <= 8'h00;
    end
    else
    begin
      clk_q <= clk_d;
      bit_cnt_q <= bit_cnt_d;
      in_sr_q <= in_sr_d;
      out_sr_q <= out_sr_d;
      cmd_done_q <= cmd_done_d;
      rnw_q <= rnw_d;
      inc_q <= inc_d;
      addr_q <= addr_d;
      load_q <= load_d;
      sdo_q <= sdo_d;
      oe_q <= oe_d;
      wr_vld_q <= wr_vld_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
    end
  end

  assign o_spi_sdo = sdo_q;
  assign o_spi_sdo_oe = oe_q;
  assign o_rd_addr = addr_q;
  assign o_wr_vld = wr_vld_q;
  assign o_wr_addr = wr_addr_q;
  assign o_wr_data = wr_data_q;

endmodule

// ---- design/srb_register_bank.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: 8-bit register bank of the pressure and temperature sensor.
// Assumes: Reset is the power-up boot; serial pins follow the system clock.
// Notes:   Reached by the four-wire serial port or by a two-wire byte port.
//
// Functional notes
// - Every register is one byte wide.
// - Seven-bit register address selects each register.
// - Power-up reloads calibration registers with defaults.
// - Address 08h holds reference bits seven to zero.
// - Address 09h holds middle reference byte; summed.
// - Address 0Ah holds top reference byte, reset zero.
// - Increment flag advances address after each byte.
// - Sub-address top bit increments; low seven address.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
module srb_register_bank
  import srb_pkg::*;
#(
  // Identity value; arbitrary, not tied to any real part.
  parameter logic [7:0] IDENTITY = 8'h5A
)
(
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Four-wire serial pins.
  input wire logic i_spi_cs_b,
  input wire logic i_spi_clk,
  input wire logic i_spi_sdi,
  output logic o_spi_sdo,
  output logic o_spi_sdo_oe,
  // Two-wire byte port from the protocol engine.
  input wire logic i_i2c_sub_vld,
  input wire logic [7:0] i_i2c_sub,
  input wire logic i_i2c_wr_vld,
  input wire logic [srb_pkg::DATA_W-1:0] i_i2c_wr_data,
  input wire logic i_i2c_rd_ack,
  output logic [srb_pkg::DATA_W-1:0] o_i2c_rd_data,
  // Measurement and status inputs from the sensor core.
  input wire logic [srb_pkg::PRESS_W-1:0] i_raw_pressure,
  input wire logic [srb_pkg::TEMP_W-1:0] i_temperature,
  input wire logic [7:0] i_event_source,
  input wire logic [7:0] i_sample_status,
  input wire logic [7:0] i_queue_status,
  // Configuration outputs to the sensor core.
  output logic [7:0] o_averaging_config,
  output logic [7:0] o_control_one,
  output logic [7:0] o_control_two,
  output logic [7:0] o_control_three,
  output logic [7:0] o_control_four,
  output logic [7:0] o_threshold_event_config,
  output logic [7:0] o_queue_control,
  output logic [15:0] o_threshold,
  output logic [15:0] o_pressure_offset,
  output logic [srb_pkg::PRESS_W-1:0] o_ref_pressure,
  output logic [srb_pkg::PRESS_W-1:0] o_pressure
);
  import srb_pkg::*;

  // Writable registers and their next values.
  logic [7:0] ref_low_bits_q, ref_low_bits_d;
  logic [7:0] ref_mid_bits_q, ref_mid_bits_d;
  logic [7:0] ref_high_bits_q, ref_high_bits_d;
  logic [7:0] avg_q, avg_d;
  logic [7:0] ctl1_q, ctl1_d;
  logic [7:0] ctl2_q, ctl2_d;
  logic [7:0] ctl3_q, ctl3_d;
  logic [7:0] ctl4_q, ctl4_d;
  logic [7:0] evt_cfg_q, evt_cfg_d;
  logic [7:0] queue_ctl_q, queue_ctl_d;
  logic [7:0] ths_low_q, ths_low_d;
  logic [7:0] ths_high_q, ths_high_d;
  logic [7:0] ofs_low_q, ofs_low_d;
  logic [7:0] ofs_high_q, ofs_high_d;
  // Two-wire address pointer, increment mode and read data.
  logic [ADDR_W-1:0] i2c_addr_q, i2c_addr_d;
  logic i2c_inc_q, i2c_inc_d;
  logic [7:0] i2c_rd_q, i2c_rd_d;
  // Serial slave register side.
  logic [ADDR_W-1:0] spi_rd_addr;
  logic [7:0] spi_rd_data;
  logic spi_wr_vld;
  logic [ADDR_W-1:0] spi_wr_addr;
  logic [7:0] spi_wr_data;
  // Selected write.
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;
  // Assembled reference pressure.
  logic [PRESS_W-1:0] ref_pressure;

  //////////////////////////////////////////////////////////////////////////
  // Read decode shared by both ports; unmapped addresses read as zero.
  function automatic logic [7:0] read_mux(input logic [ADDR_W-1:0] addr);
    case (addr)
      OFS_REF_LOW: read_mux = ref_low_bits_q;
      OFS_REF_MID: read_mux = ref_mid_bits_q;
      OFS_REF_HIGH: read_mux = ref_high_bits_q;
      OFS_IDENTITY: read_mux = IDENTITY;
      OFS_AVG_CONFIG: read_mux = avg_q;
      OFS_CONTROL_ONE: read_mux = ctl1_q;
      OFS_CONTROL_TWO: read_mux = ctl2_q;
      OFS_CONTROL_THREE: read_mux = ctl3_q;
      OFS_CONTROL_FOUR: read_mux = ctl4_q;
      OFS_EVENT_CONFIG: read_mux = evt_cfg_q;
      OFS_EVENT_SOURCE: read_mux = i_event_source;
      OFS_SAMPLE_STATUS: read_mux = i_sample_status;
      OFS_PRESS_LOW: read_mux = o_pressure[7:0];
      OFS_PRESS_MID: read_mux = o_pressure[15:8];
      OFS_PRESS_HIGH: read_mux = o_pressure[23:16];
      OFS_TEMP_LOW: read_mux = i_temperature[7:0];
      OFS_TEMP_HIGH: read_mux = i_temperature[15:8];
      OFS_QUEUE_CONTROL: read_mux = queue_ctl_q;
      OFS_QUEUE_STATUS: read_mux = i_queue_status;
      OFS_THRESH_LOW: read_mux = ths_low_q;
      OFS_THRESH_HIGH: read_mux = ths_high_q;
      OFS_OFFSET_LOW: read_mux = ofs_low_q;
      OFS_OFFSET_HIGH: read_mux = ofs_high_q;
      default: read_mux = 8'h00;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Four-wire serial front end.
  srb_spi_slave u_spi
  (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_spi_cs_b(i_spi_cs_b),
    .i_spi_clk(i_spi_clk),
    .i_spi_sdi(i_spi_sdi),
    .o_spi_sdo(o_spi_sdo),
    .o_spi_sdo_oe(o_spi_sdo_oe),
    .o_rd_addr(spi_rd_addr),
    .i_rd_data(spi_rd_data),
    .o_wr_vld(spi_wr_vld),
    .o_wr_addr(spi_wr_addr),
    .o_wr_data(spi_wr_data)
  );

  // Serial read data is looked up at the slave's current address.
  always_comb
  begin
    spi_rd_data = read_mux(spi_rd_addr);
  end

  //////////////////////////////////////////////////////////////////////////
  // Two-wire pointer: loaded from the sub-address, advanced per byte.
  always_comb
  begin
    i2c_addr_d = i2c_addr_q;
    i2c_inc_d = i2c_inc_q;
    if (i_i2c_sub_vld)
    begin
      i2c_inc_d = i_i2c_sub[SUB_INC_BIT];
      i2c_addr_d = i_i2c_sub[ADDR_W-1:0];
    end
    else if (i_i2c_wr_vld || i_i2c_rd_ack)
    begin
      i2c_addr_d = srb_next_addr(i2c_addr_q, i2c_inc_q);
    end
    i2c_rd_d = read_mux(i2c_addr_q);
  end

  // Two-wire pointer registers.
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      i2c_addr_q <= 7'h00;
      i2c_inc_q <= 1'b0;
      i2c_rd_q <= 8'h00;
    end
    else
    begin
      i2c_addr_q <= i2c_addr_d;
      i2c_inc_q <= i2c_inc_d;
      i2c_rd_q <= i2c_rd_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register writes. The four-wire port wins a same-cycle clash, since a
  // host uses only one port at a time. Reserved and read-only addresses
  // are simply ignored, so a stray write there changes no register.
  always_comb
  begin
    wr_en = spi_wr_vld || i_i2c_wr_vld;
    wr_addr = spi_wr_vld ? spi_wr_addr : i2c_addr_q;
    wr_data = spi_wr_vld ? spi_wr_data : i_i2c_wr_data;
    ref_low_bits_d = ref_low_bits_q;
    ref_mid_bits_d = ref_mid_bits_q;
    ref_high_bits_d = ref_high_bits_q;
    avg_d = avg_q;
    ctl1_d = ctl1_q;
    ctl2_d = ctl2_q;
    ctl3_d = ctl3_q;
    ctl4_d = ctl4_q;
    evt_cfg_d = evt_cfg_q;
    queue_ctl_d = queue_ctl_q;
    ths_low_d = ths_low_q;
    ths_high_d = ths_high_q;
    ofs_low_d = ofs_low_q;
    ofs_high_d = ofs_high_q;
    if (wr_en)
    begin
      case (wr_addr)
        OFS_REF_LOW: ref_low_bits_d = wr_data;
        OFS_REF_MID: ref_mid_bits_d = wr_data;
        OFS_REF_HIGH: ref_high_bits_d = wr_data;
        OFS_AVG_CONFIG: avg_d = wr_data;
        OFS_CONTROL_ONE: ctl1_d = wr_data;
        OFS_CONTROL_TWO: ctl2_d = wr_data;
        OFS_CONTROL_THREE: ctl3_d = wr_data;
        OFS_CONTROL_FOUR: ctl4_d = wr_data;
        OFS_EVENT_CONFIG: evt_cfg_d = wr_data;
        OFS_QUEUE_CONTROL: queue_ctl_d = wr_data;
        OFS_THRESH_LOW: ths_low_d = wr_data;
        OFS_THRESH_HIGH: ths_high_d = wr_data;
        OFS_OFFSET_LOW: ofs_low_d = wr_data;
        OFS_OFFSET_HIGH: ofs_high_d = wr_data;
        default: ;
      endcase
    end
  end

  // Register file; reset stands for power-up and restores calibration.
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ref_low_bits_q <= RST_ZERO;
      ref_mid_bits_q <= RST_ZERO;
      ref_high_bits_q <= RST_ZERO;
      avg_q <= RST_AVG_CONFIG;
      ctl1_q <= RST_ZERO;
      ctl2_q <= RST_ZERO;
      ctl3_q <= RST_ZERO;
      ctl4_q <= RST_ZERO;
      evt_cfg_q <= RST_ZERO;
      queue_ctl_q <= RST_ZERO;
      ths_low_q <= RST_ZERO;
      ths_high_q <= RST_ZERO;
      ofs_low_q <= RST_OFFSET_LOW;
      ofs_high_q <= RST_OFFSET_HIGH;
    end
    else
    begin
      ref_low_bits_q <= ref_low_bits_d;
      ref_mid_bits_q <= ref_mid_bits_d;
      ref_high_bits_q <= ref_high_bits_d;
      avg_q <= avg_d;
      ctl1_q <= ctl1_d;
      ctl2_q <= ctl2_d;
      ctl3_q <= ctl3_d;
      ctl4_q <= ctl4_d;
      evt_cfg_q <= evt_cfg_d;
      queue_ctl_q <= queue_ctl_d;
      ths_low_q <= ths_low_d;
      ths_high_q <= ths_high_d;
      ofs_low_q <= ofs_low_d;
      ofs_high_q <= ofs_high_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Reference assembly and the corrected pressure output.
  always_comb
  begin
    ref_pressure = {ref_high_bits_q, ref_mid_bits_q, ref_low_bits_q};
  end

  srb_pressure_adder #(
    .WIDTH(PRESS_W)
  ) u_adder
  (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_raw_pressure(i_raw_pressure),
    .i_ref_pressure(ref_pressure),
    .o_pressure(o_pressure)
  );

  // Configuration outputs come straight from the register flip-flops.
  assign o_i2c_rd_data = i2c_rd_q;
  assign o_averaging_config = avg_q;
  assign o_control_one = ctl1_q;
  assign o_control_two = ctl2_q;
  assign o_control_three = ctl3_q;
  assign o_control_four = ctl4_q;
  assign o_threshold_event_config = evt_cfg_q;
  assign o_queue_control = queue_ctl_q;
  assign o_threshold = {ths_high_q, ths_low_q};
  assign o_pressure_offset = {ofs_high_q, ofs_low_q};
  assign o_ref_pressure = ref_pressure;

endmodule

// ---- sim/srb_host_model.sv ----
// Purpose: Host side of the four-wire serial link to the register bank.
// Assumes: Each serial clock phase spans four system clocks.
// Notes:   Serial clock idles high; a released data line reads as unknown.
`timescale 1ns/1ns
module srb_host_model (
  // Pacing clock.
  input wire logic i_sys_clk,
  // Serial pins toward the device.
  output logic o_cs_b,
  output logic o_sck,
  output logic o_sdi,
  input wire logic i_sdo,
  input wire logic i_sdo_oe
);
  // Data bytes sent after the command and bytes received.
  logic [7:0] tx_b [4];
  logic [7:0] rx_b [4];
  // The clock stands high between frames.
  initial
  begin
    o_cs_b = 1'b1;
    o_sck = 1'b1;
    o_sdi = 1'b0;
  end
  // One byte, MSb first: set on the fall, taken on the rise.
  // An undriven line reads as unknown, so silence cannot pass.
  task automatic put_byte(input logic [7:0] v, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
    begin
      repeat (4) @(negedge i_sys_clk);
      o_sck = 1'b0;
      o_sdi = v[i];
      repeat (4) @(negedge i_sys_clk);
      o_sck = 1'b1;
      r[i] = i_sdo_oe ? i_sdo : 1'bx;
    end
  endtask
  // Command byte {read, increment, address}, then n data bytes.
  task automatic xfer(input logic rnw, input logic inc,
    input logic [5:0] a, input int n);
    @(negedge i_sys_clk);
    o_cs_b = 1'b0;
    put_byte({rnw, inc, a}, rx_b[3]);
    for (int k = 0; k < n; k++)
      put_byte(tx_b[k], rx_b[k]);
    repeat (4) @(negedge i_sys_clk);
    o_cs_b = 1'b1;
    o_sdi = ~o_sdi;
  endtask
endmodule

// ---- sim/srb_register_bank_assertions.sv ----
// Purpose: Port-level checks of the sensor register bank.
// Assumes: One clock; asynchronous active-low reset.
// Notes:   Two-wire reads are checked with the bank held still.
`timescale 1ns/1ns
module srb_register_bank_assertions
#(
  parameter logic [7:0] IDENTITY = 8'h5A
)
(
  input logic i_sys_clk,
  input logic i_rst_b,
  input logic i_spi_cs_b,
  input logic o_spi_sdo_oe,
  input logic i_i2c_sub_vld,
  input logic [7:0] i_i2c_sub,
  input logic i_i2c_wr_vld,
  input logic i_i2c_rd_ack,
  input logic [7:0] o_i2c_rd_data,
  input logic [srb_pkg::PRESS_W-1:0] i_raw_pressure,
  input logic [7:0] o_averaging_config,
  input logic [7:0] o_control_one,
  input logic [15:0] o_pressure_offset,
  input logic [srb_pkg::PRESS_W-1:0] o_ref_pressure,
  input logic [srb_pkg::PRESS_W-1:0] o_pressure
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // No two-wire request in this cycle.
  wire quiet = !i_i2c_sub_vld && !i_i2c_wr_vld && !i_i2c_rd_ack;
  pressure_sum_a: assert property (
    $past(i_rst_b) |-> o_pressure == $past(i_raw_pressure + o_ref_pressure))
    else $error("pressure sum wrong");
  sdo_release_a: assert property (
    i_spi_cs_b [*3] |-> !o_spi_sdo_oe) else $error("sdo driven when idle");
  boot_values_a: assert property (
    $rose(i_rst_b) |-> o_averaging_config == 8'h05 &&
    o_pressure_offset == 16'h0038 && o_ref_pressure == '0)
    else $error("boot values wrong");
  config_hold_a: assert property (
    i_spi_cs_b [*4] ##0 !i_i2c_wr_vld && !$past(i_i2c_wr_vld) |=>
    $stable({o_ref_pressure, o_control_one, o_averaging_config}))
    else $error("register changed without write");
  high_byte_read_a: assert property (
    i_i2c_sub_vld && i_i2c_sub[6:0] == 7'h0A ##1 quiet ##1
    $stable(o_ref_pressure) |-> o_i2c_rd_data == o_ref_pressure[23:16])
    else $error("high reference byte read wrong");
  identity_read_a: assert property (
    i_i2c_sub_vld && i_i2c_sub[6:0] == 7'h0F ##1 quiet |=>
    o_i2c_rd_data == IDENTITY) else $error("identity read wrong");
  reserved_read_a: assert property (
    i_i2c_sub_vld && i_i2c_sub[6:0] == 7'h11 ##1 quiet |=>
    o_i2c_rd_data == 8'h00) else $error("reserved read not zero");
  inc_read_a: assert property (
    i_i2c_sub_vld && i_i2c_sub[6:0] == 7'h08 ##1 quiet ##1
    i_i2c_rd_ack && !i_i2c_sub_vld ##1 quiet ##1
    $stable(o_ref_pressure) |-> o_i2c_rd_data == ($past(i_i2c_sub[7], 4) ?
    o_ref_pressure[15:8] : o_ref_pressure[7:0]))
    else $error("pointer step wrong");
endmodule
bind srb_register_bank srb_register_bank_assertions #(.IDENTITY(IDENTITY))
  u_chk (.*);

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the sensor register bank.
// Assumes: Host model paces serial frames; byte port is driven here.
// Notes:   Expected values are worked out by the bench alone.
`timescale 1ns/1ns
module tb_top;
  import srb_pkg::*;
  // Arbitrary identity value.
  localparam logic [7:0] ID = 8'hC3;
  localparam logic [6:0] RW_T [13] = '{7'h08, 7'h09, 7'h0A, 7'h10, 7'h20,
    7'h21, 7'h22, 7'h23, 7'h24, 7'h2E, 7'h30, 7'h31, 7'h3A};
  localparam logic [6:0] RSV_T [5] = '{7'h00, 7'h11, 7'h26, 7'h2D, 7'h38};
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic cs_b, sck, sdi, sdo, sdo_oe;
  logic sub_vld = 1'b0, wr_vld = 1'b0, rd_ack = 1'b0;
  logic [7:0] sub = 8'h00, wdat = 8'h00, rdat, avg, c1, c2;
  logic [7:0] evs = 8'h00, sts = 8'h00, qst = 8'h00;
  logic [15:0] temp = 16'h0000, offs;
  logic [23:0] raw = 24'h000000, ref_p, press;
  int n_fail = 0, checks_done = 0;
  always #2 i_sys_clk = ~i_sys_clk;
  srb_register_bank #(.IDENTITY(ID)) uut (
    .i_sys_clk, .i_rst_b,
    .i_spi_cs_b(cs_b), .i_spi_clk(sck), .i_spi_sdi(sdi),
    .o_spi_sdo(sdo), .o_spi_sdo_oe(sdo_oe),
    .i_i2c_sub_vld(sub_vld), .i_i2c_sub(sub), .i_i2c_wr_vld(wr_vld),
    .i_i2c_wr_data(wdat), .i_i2c_rd_ack(rd_ack), .o_i2c_rd_data(rdat),
    .i_raw_pressure(raw), .i_temperature(temp), .i_event_source(evs),
    .i_sample_status(sts), .i_queue_status(qst),
    .o_averaging_config(avg), .o_control_one(c1), .o_control_two(c2),
    .o_control_three(), .o_control_four(),
    .o_threshold_event_config(), .o_queue_control(), .o_threshold(),
    .o_pressure_offset(offs), .o_ref_pressure(ref_p), .o_pressure(press));
  srb_host_model host (.i_sys_clk, .o_cs_b(cs_b), .o_sck(sck),
    .o_sdi(sdi), .i_sdo(sdo), .i_sdo_oe(sdo_oe));
  // Value comparison; unknowns never match.
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d fails=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Two's complement add; same bits as unsigned with wrap.
  function automatic logic [23:0] sum_p(input logic [23:0] r, f);
    sum_p = r + f;
  endfunction
  task automatic wr1(input logic [6:0] a, input logic [7:0] d);
    host.tx_b[0] = d;
    host.xfer(1'b0, 1'b0, a[5:0], 1);
  endtask
  task automatic rd1(input logic [6:0] a, output logic [7:0] d);
    host.xfer(1'b1, 1'b0, a[5:0], 1);
    d = host.rx_b[0];
  endtask
  // Waits n falling clock edges.
  task automatic nc(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  // Byte port request: 0 sub-address, 1 write, 2 read acknowledge.
  task automatic i2c(input logic [1:0] k, input logic [7:0] v, input int w);
    nc(1);
    {sub_vld, wr_vld, rd_ack} = 3'b100 >> k;
    {sub, wdat} = {v, v};
    nc(1);
    {sub_vld, wr_vld, rd_ack} = '0;
    nc(w);
  endtask
  // A hang costs one failure and ends the run.
  initial
  begin
    #400000;
    n_fail++;
    summarize();
  end
  initial
  begin
    logic [7:0] b, r;
    logic [6:0] a;
    logic [23:0] e;
    void'($urandom(32'hDF00F822));
    nc(16);
    i_rst_b = 1'b1;
    nc(2);
    chk(avg, 8'h05);
    chk(offs, 16'h0038);
    chk(ref_p, 24'h000000);
    // Negative reference written in one incrementing frame.
    e = $urandom | 24'h800000;
    for (int k = 0; k < 3; k++)
      host.tx_b[k] = e[8*k+:8];
    raw = $urandom;
    host.xfer(1'b0, 1'b1, 6'h08, 3);
    nc(4);
    chk(ref_p, e);
    chk(press, sum_p(raw, e));
    host.xfer(1'b1, 1'b1, 6'h28, 3);
    chk({host.rx_b[2], host.rx_b[1], host.rx_b[0]}, sum_p(raw, e));
    host.xfer(1'b1, 1'b0, 6'h08, 2);
    chk({host.rx_b[1], host.rx_b[0]}, {2{e[7:0]}});
    b = $urandom;
    host.tx_b[0] = ~b;
    host.tx_b[1] = b;
    host.xfer(1'b0, 1'b0, 6'h20, 2);
    chk({c2, c1}, {8'h00, b});
    rd1(7'h0F, r);
    chk(r, ID);
    foreach (RSV_T[i])
    begin
      rd1(RSV_T[i], r);
      chk(r, 8'h00);
    end
    // Read-only places follow the core inputs.
    evs = $urandom;
    qst = $urandom;
    temp = $urandom;
    host.xfer(1'b1, 1'b1, 6'h2B, 2);
    chk({host.rx_b[1], host.rx_b[0]}, temp);
    rd1(7'h25, r);
    chk(r, evs);
    rd1(7'h2F, r);
    chk(r, qst);
    repeat (10)
    begin
      a = RW_T[$urandom_range(12)];
      b = $urandom;
      wr1(a, b);
      rd1(a, r);
      chk(r, b);
    end
    // Byte port: incrementing write, then stepped and fixed reads.
    e = $urandom;
    i2c(2'd0, 8'h88, 2);
    for (int k = 0; k < 3; k++)
      i2c(2'd1, e[8*k+:8], 2);
    chk(ref_p, e);
    i2c(2'd0, 8'h88, 0);
    i2c(2'd2, 8'h00, 2);
    chk(rdat, e[15:8]);
    i2c(2'd0, 8'h08, 0);
    i2c(2'd2, 8'h00, 2);
    chk(rdat, e[7:0]);
    i2c(2'd0, 8'h0A, 2);
    chk(rdat, e[23:16]);
    i2c(2'd0, 8'h0F, 2);
    chk(rdat, ID);
    i2c(2'd0, 8'h11, 2);
    chk(rdat, 8'h00);
    // Calibration overwritten, then a second boot restores it.
    wr1(7'h10, 8'hFA);
    wr1(7'h39, $urandom);
    i_rst_b = 1'b0;
    nc(3);
    chk(avg, 8'h05);
    chk(offs, 16'h0038);
    i_rst_b = 1'b1;
    nc(2);
    summarize();
  end
endmodule
